// File: tb/peripheral_pin_routing_bench.sv
`timescale 1ns/1ns
`default_nettype none
module peripheral_pin_routing_bench;
  logic        ref_clk = 0, nrst = 0, sel_wr_en = 0, sel_is_output = 0;
  logic        rd_is_output = 0, lock_wr_en = 0, one_time_lock_config = 0;
  logic [4:0]  sel_index = 0, sel_wdata = 0, rd_index = 0, rd_data;
  logic [7:0]  lock_wdata = 0, pattern = 0, periph_in;
  logic [23:0] input_level_select = 24'h5a_c3_f0;
  logic [23:0] pin_out, pin_oe_n, pin_i2c_thresh, pin_std_schmitt;
  logic        selection_lock_bit, exp_lock;
  wire  [23:0] pin_in, port_latch, latch_oe_n;
  wire  [31:0] periph_out, periph_oe_n;
  logic [4:0]  exp_in [8];
  logic [4:0]  exp_out [24];
  int          miscompares = 0, n_tests = 0;

  ppr_routing dut (.ref_clk, .nrst, .sel_wr_en, .sel_is_output, .sel_index,
    .sel_wdata, .rd_is_output, .rd_index, .lock_wr_en, .lock_wdata,
    .one_time_lock_config, .pin_in, .port_latch, .latch_oe_n, .periph_out,
    .periph_oe_n, .input_level_select, .periph_in, .pin_out, .pin_oe_n,
    .pin_i2c_thresh, .pin_std_schmitt, .rd_data, .selection_lock_bit);
  ppr_far_side far (.pattern, .pin_in, .port_latch, .latch_oe_n, .periph_out,
    .periph_oe_n);

  initial forever #20 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset();
    nrst = 0;
    repeat (3) @(posedge ref_clk);
    #1 nrst = 1;
    exp_lock = 0;
    for (int k = 0; k < 8; k++)
      exp_in[k] = ppr_pkg::IN_DEFAULT[k*5 +: 5];
    for (int p = 0; p < 24; p++)
      exp_out[p] = ppr_pkg::OUT_SEL_LATCH;
  endtask

  task automatic check_all();
    logic [23:0] eo, eoe, eth;
    logic [7:0]  ei;
    pattern = pattern + 8'h3b;
    @(posedge ref_clk);
    #1;
    for (int p = 0; p < 24; p++)
    begin
      eo[p] = exp_out[p] == 0 ? port_latch[p] : periph_out[exp_out[p]];
      eoe[p] = exp_out[p] == 0 ? latch_oe_n[p] : periph_oe_n[exp_out[p]];
      eth[p] = ppr_pkg::I2C_CAP_PINS[p] && (exp_in[0] == p || exp_in[1] == p);
    end
    for (int k = 0; k < 8; k++)
      ei[k] = pin_in[exp_in[k]];
    chk("pin_out", eo, pin_out);
    chk("pin_oe_n", eoe, pin_oe_n);
    chk("periph_in", ei, periph_in);
    chk("pin_i2c_thresh", eth, pin_i2c_thresh);
    chk("pin_std_schmitt", input_level_select & ~eth, pin_std_schmitt);
    chk("selection_lock_bit", exp_lock, selection_lock_bit);
  endtask

  task automatic rd_chk(input logic o, input logic [4:0] i, e);
    rd_is_output = o;
    rd_index = i;
    @(posedge ref_clk);
    #1 chk("rd_data", e, rd_data);
  endtask

  task automatic sel_wr(input logic o, input logic [4:0] i, d);
    @(posedge ref_clk);
    #1 sel_is_output = o;
    sel_index = i;
    sel_wdata = d;
    sel_wr_en = 1;
    @(posedge ref_clk);
    #1 sel_wr_en = 0;
    if (!exp_lock && o)
      exp_out[i] = d;
    else if (!exp_lock)
      exp_in[i] = d;
  endtask

  task automatic lock_wr(input logic [7:0] d);
    @(posedge ref_clk);
    #1 lock_wdata = d;
    lock_wr_en = 1;
    @(posedge ref_clk);
    #1 lock_wr_en = 0;
  endtask

  task automatic lock_seq(input logic [7:0] k2, input logic b, e);
    lock_wr(ppr_pkg::UNLOCK_KEY1);
    lock_wr(k2);
    lock_wr({7'h00, b});
    exp_lock = e;
    chk("selection_lock_bit", e, selection_lock_bit);
  endtask

  task automatic t_defaults();
    check_all();
    rd_chk(1'b0, 5'h00, ppr_pkg::PIN_C0);
    rd_chk(1'b1, 5'h10, ppr_pkg::OUT_SEL_LATCH);
    rd_chk(1'b0, 5'h09, 5'h00);
  endtask

  task automatic t_pair();
    input_level_select = 24'ha5_3c_0f;
    sel_wr(1'b0, ppr_pkg::IN_SYNC1_CLK, 5'h03);
    check_all();
    sel_wr(1'b0, ppr_pkg::IN_SYNC1_CLK, ppr_pkg::PIN_C0);
    sel_wr(1'b1, 5'h10, ppr_pkg::OUT_SEL_SYNC1_CLK);
    chk("pin_out_c0", periph_out[24], pin_out[16]);
    check_all();
    sel_wr(1'b0, ppr_pkg::IN_SER1_DATA, 5'h09);
    sel_wr(1'b1, 5'h09, 5'h05);
    check_all();
  endtask

  task automatic t_lock();
    lock_seq(ppr_pkg::UNLOCK_KEY2, 1'b1, 1'b1);
    sel_wr(1'b1, 5'h02, 5'h07);
    check_all();
    rd_chk(1'b1, 5'h10, ppr_pkg::OUT_SEL_SYNC1_CLK);
    lock_seq(8'h00, 1'b0, 1'b1);
    lock_seq(ppr_pkg::UNLOCK_KEY2, 1'b0, 1'b0);
    sel_wr(1'b1, 5'h02, 5'h07);
    check_all();
  endtask

  task automatic t_por_and_once();
    lock_seq(ppr_pkg::UNLOCK_KEY2, 1'b1, 1'b1);
    do_reset();
    check_all();
    rd_chk(1'b1, 5'h02, 5'h00);
    one_time_lock_config = 1;
    lock_seq(ppr_pkg::UNLOCK_KEY2, 1'b1, 1'b1);
    lock_seq(ppr_pkg::UNLOCK_KEY2, 1'b0, 1'b0);
    lock_seq(ppr_pkg::UNLOCK_KEY2, 1'b1, 1'b0);
    sel_wr(1'b1, 5'h03, 5'h1f);
    check_all();
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    do_reset();
    t_defaults();
    t_pair();
    t_lock();
    t_por_and_once();
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: tb/ppr_far_side.sv
`timescale 1ns/1ns
`default_nettype none
module ppr_far_side
(
  input  wire logic [7:0]  pattern,
  output logic      [23:0] pin_in,
  output logic      [23:0] port_latch,
  output logic      [23:0] latch_oe_n,
  output logic      [31:0] periph_out,
  output logic      [31:0] periph_oe_n
);
  // Fresh levels on every pin and peripheral per pattern step
  assign pin_in      = {pattern, ~pattern, pattern ^ 8'h5a};
  assign port_latch  = {~pattern, pattern ^ 8'ha5, pattern};
  assign latch_oe_n  = {pattern ^ 8'h0f, ~pattern, pattern ^ 8'hf0};
  assign periph_out  = {pattern, pattern ^ 8'h3c, ~pattern, pattern ^ 8'h99};
  assign periph_oe_n = {~pattern, pattern, pattern ^ 8'h66, pattern ^ 8'hc3};
endmodule
`default_nettype wire

// File: verilog/ppr_pkg.sv
`default_nettype none
package ppr_pkg;
  localparam int N_PINS = 24;
  localparam int N_PIN_IN = 8;
  localparam int N_PERIPH_OUT = 32;
  localparam int SEL_W = 5;
  localparam int IDX_W = 5;
  localparam logic [4:0] OUT_SEL_LATCH = 5'h00;
  localparam logic [4:0] PIN_C0 = 5'h10;
  localparam logic [4:0] OUT_SEL_SYNC1_CLK = 5'h18;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam int LOCK_BIT = 0;
  localparam logic LOCK_RESET = 1'b0;
  // Peripheral input slots
  localparam int IN_SYNC1_CLK = 0;
  localparam int IN_SYNC1_DATA = 1;
  localparam int IN_SER1_CLK = 2;
  localparam int IN_SER1_DATA = 3;
  // Default source pin per peripheral input, slot 0 in the low bits
  localparam logic [39:0] IN_DEFAULT =
    {5'h00, 5'h0c, 5'h0a, 5'h03, 5'h14, 5'h15, 5'h11, 5'h10};
  // Pins with I2C-compatible input thresholds
  localparam logic [23:0] I2C_CAP_PINS = 24'h33_00_00;
  typedef enum logic [1:0]
  {
    PPR_IDLE  = 2'b00,
    PPR_KEY1  = 2'b01,
    PPR_ARMED = 2'b10
  } ppr_seq_t;
endpackage
`default_nettype wire

// File: verilog/ppr_routing.sv
// Summary of operation
// (R01) Peripheral inputs start on default pins; input select redirects them.
// (R02) Pins output their port latch unless output select names a peripheral.
// (R03) Software programs input and output select to the same pin for bidir.
// (R04) Input select code 10000 picks port C pin 0.
// (R05) Output select code 11000 drives sync port clock out on the pin.
// (R06) Serial and sync port clock and data are bidirectional, paired.
// (R07) I2C lines go anywhere; incapable pins use selected standard levels.
// (R08) Select writes reach the muxes at the writing clock edge.
// (R09) Lock bit changes only right after writing 0x55 then 0xaa.
// (R10) Locked: select writes rejected; reads always allowed.
// (R11) One-time config: lock clears and sets once per reset.
// (R12) Power-on reset restores defaults and clears lock.
`timescale 1ns/1ns
`default_nettype none
module ppr_routing
(
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic                    sel_wr_en,
  input  wire logic                    sel_is_output,
  input  wire logic [4:0]              sel_index,
  input  wire logic [4:0]              sel_wdata,
  input  wire logic                    rd_is_output,
  input  wire logic [4:0]              rd_index,
  input  wire logic                    lock_wr_en,
  input  wire logic [7:0]              lock_wdata,
  input  wire logic                    one_time_lock_config,
  input  wire logic [23:0]             pin_in,
  input  wire logic [23:0]             port_latch,
  input  wire logic [23:0]             latch_oe_n,
  input  wire logic [31:0]             periph_out,
  input  wire logic [31:0]             periph_oe_n,
  input  wire logic [23:0]             input_level_select,
  output logic [7:0]                   periph_in,
  output logic [23:0]                  pin_out,
  output logic [23:0]                  pin_oe_n,
  output logic [23:0]                  pin_i2c_thresh,
  output logic [23:0]                  pin_std_schmitt,
  output logic [4:0]                   rd_data,
  output logic                         selection_lock_bit
);
  logic [4:0]          in_sel      [ppr_pkg::N_PIN_IN];
  logic [4:0]          next_in_sel [ppr_pkg::N_PIN_IN];
  logic [4:0]          out_sel      [ppr_pkg::N_PINS];
  logic [4:0]          next_out_sel [ppr_pkg::N_PINS];
  logic [7:0]          next_periph_in;
  logic [23:0]         next_pin_out;
  logic [23:0]         next_pin_oe_n;
  logic [23:0]         i2c_routed;
  logic [23:0]         next_pin_i2c_thresh;
  logic [23:0]         next_pin_std_schmitt;
  logic [4:0]          next_rd_data;
  ppr_pkg::ppr_seq_t   seq;
  logic                next_lock;
  logic                cleared_once;
  logic                set_once;
  logic                next_cleared_once;
  logic                next_set_once;
  ppr_pkg::ppr_seq_t   next_seq;
  logic                sel_write_ok;

  assign sel_write_ok = sel_wr_en && !selection_lock_bit; // R10

  genvar g;
  generate
    for (g = 0; g < ppr_pkg::N_PIN_IN; g++)
    begin : g_in
      always_comb
      begin
        next_in_sel[g] = in_sel[g];
        if (sel_write_ok && !sel_is_output && sel_index == 5'(g))
          next_in_sel[g] = sel_wdata; // R01
        // Codes beyond the pin range read low
        if (next_in_sel[g] < 5'(ppr_pkg::N_PINS))
          next_periph_in[g] = pin_in[next_in_sel[g]]; // R04 R08
        else
          next_periph_in[g] = 1'b0;
      end
    end
    for (g = 0; g < ppr_pkg::N_PINS; g++)
    begin : g_pin
      always_comb
      begin
        next_out_sel[g] = out_sel[g];
        if (sel_write_ok && sel_is_output && sel_index == 5'(g))
          next_out_sel[g] = sel_wdata; // R02
        if (next_out_sel[g] == ppr_pkg::OUT_SEL_LATCH)
        begin
          next_pin_out[g] = port_latch[g]; // R02
          next_pin_oe_n[g] = latch_oe_n[g];
        end
        else
        begin
          next_pin_out[g] = periph_out[next_out_sel[g]]; // R05 R08
          next_pin_oe_n[g] = periph_oe_n[next_out_sel[g]]; // R06
        end
        i2c_routed[g] =
          (next_in_sel[ppr_pkg::IN_SYNC1_CLK] == 5'(g)) ||
          (next_in_sel[ppr_pkg::IN_SYNC1_DATA] == 5'(g));
        next_pin_i2c_thresh[g] = i2c_routed[g] && ppr_pkg::I2C_CAP_PINS[g];
        next_pin_std_schmitt[g] = !next_pin_i2c_thresh[g] &&
          input_level_select[g]; // R07
      end
    end
  endgenerate

  always_comb
  begin
    if (rd_is_output)
      next_rd_data = (rd_index < 5'(ppr_pkg::N_PINS)) ?
        out_sel[rd_index] : 5'h00; // R10
    else
      next_rd_data = (rd_index < 5'(ppr_pkg::N_PIN_IN)) ?
        in_sel[rd_index[2:0]] : 5'h00;
  end

  always_comb
  begin
    next_seq = seq;
    next_lock = selection_lock_bit;
    next_cleared_once = cleared_once;
    next_set_once = set_once;
    if (lock_wr_en)
    begin
      case (seq)
        ppr_pkg::PPR_IDLE:
          next_seq = (lock_wdata == ppr_pkg::UNLOCK_KEY1) ?
            ppr_pkg::PPR_KEY1 : ppr_pkg::PPR_IDLE;
        ppr_pkg::PPR_KEY1:
          next_seq = (lock_wdata == ppr_pkg::UNLOCK_KEY2) ?
            ppr_pkg::PPR_ARMED : ppr_pkg::PPR_IDLE;
        ppr_pkg::PPR_ARMED:
        begin
          next_seq = ppr_pkg::PPR_IDLE;
          if (lock_wdata[ppr_pkg::LOCK_BIT] && !selection_lock_bit &&
              !(one_time_lock_config && set_once))
          begin
            next_lock = 1'b1; // R09
            next_set_once = 1'b1; // R11
          end
          else if (!lock_wdata[ppr_pkg::LOCK_BIT] && selection_lock_bit &&
                   !(one_time_lock_config && cleared_once))
          begin
            next_lock = 1'b0; // R09
            next_cleared_once = 1'b1; // R11
          end
        end
        default:
          next_seq = ppr_pkg::PPR_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < ppr_pkg::N_PIN_IN; i++)
        in_sel[i] <= ppr_pkg::IN_DEFAULT[5*i +: 5]; // R12
      for (int i = 0; i < ppr_pkg::N_PINS; i++)
        out_sel[i] <= ppr_pkg::OUT_SEL_LATCH; // R12
      periph_in <= 8'h00;
      pin_out <= 24'h000000;
      pin_oe_n <= 24'hffffff;
      pin_i2c_thresh <= 24'h000000;
      pin_std_schmitt <= 24'h000000;
      rd_data <= 5'h00;
      selection_lock_bit <= ppr_pkg::LOCK_RESET; // R12
      cleared_once <= 1'b0;
      set_once <= 1'b0;
      seq <= ppr_pkg::PPR_IDLE;
    end
    else
    begin
      in_sel <= next_in_sel;
      out_sel <= next_out_sel;
      periph_in <= next_periph_in;
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
      pin_i2c_thresh <= next_pin_i2c_thresh;
      pin_std_schmitt <= next_pin_std_schmitt;
      rd_data <= next_rd_data;
      selection_lock_bit <= next_lock;
      cleared_once <= next_cleared_once;
      set_once <= next_set_once;
      seq <= next_seq;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_in_write;
    sel_write_ok && !sel_is_output && sel_index == 5'h00 ##1 1'b1
      |-> in_sel[0] == $past(sel_wdata);
  endproperty
  a_in_write: assert property (p_in_write) // R01
    else $error("input select lost");

  property p_latch_default;
    out_sel[3] == ppr_pkg::OUT_SEL_LATCH && !sel_wr_en
      |=> pin_out[3] == $past(port_latch[3]);
  endproperty
  a_latch_default: assert property (p_latch_default) // R02
    else $error("latch bad");

  property p_c0_source;
    in_sel[0] == ppr_pkg::PIN_C0 && !sel_wr_en
      |=> periph_in[0] == $past(pin_in[16]);
  endproperty
  a_c0_source: assert property (p_c0_source) // R04
    else $error("C0 not routed");

  property p_clk_out;
    out_sel[16] == ppr_pkg::OUT_SEL_SYNC1_CLK && !sel_wr_en
      |=> pin_out[16] == $past(periph_out[24]) &&
          pin_oe_n[16] == $past(periph_oe_n[24]);
  endproperty
  a_clk_out: assert property (p_clk_out) // R05 R06
    else $error("clock out bad");

  // Capable pin C0 takes I2C levels only while a sync port input sits there
  property p_i2c_level;
    pin_i2c_thresh[16] |-> !pin_std_schmitt[16] &&
      (in_sel[ppr_pkg::IN_SYNC1_CLK] == ppr_pkg::PIN_C0 ||
       in_sel[ppr_pkg::IN_SYNC1_DATA] == ppr_pkg::PIN_C0);
  endproperty
  a_i2c_level: assert property (p_i2c_level) // R07
    else $error("level clash");

  property p_next_cycle;
    sel_write_ok && sel_is_output && sel_index == 5'h10 &&
      sel_wdata == ppr_pkg::OUT_SEL_SYNC1_CLK
      |=> pin_out[16] == $past(periph_out[24]) &&
          pin_oe_n[16] == $past(periph_oe_n[24]);
  endproperty
  a_next_cycle: assert property (p_next_cycle) // R08
    else $error("late route");

  property p_lock_needs_key;
    $changed(selection_lock_bit) |-> $past(seq) == ppr_pkg::PPR_ARMED &&
      $past(lock_wr_en);
  endproperty
  a_lock_needs_key: assert property (p_lock_needs_key) // R09
    else $error("lock no key");

  property p_locked_hold;
    selection_lock_bit && sel_wr_en && sel_is_output && sel_index == 5'h02
      |=> $stable(out_sel[2]);
  endproperty
  a_locked_hold: assert property (p_locked_hold) // R10
    else $error("locked write");

  property p_one_way;
    one_time_lock_config && set_once && !selection_lock_bit
      |=> !selection_lock_bit;
  endproperty
  a_one_way: assert property (p_one_way) // R11
    else $error("relocked twice");

  c_lock: cover property ($rose(selection_lock_bit));
  c_unlock: cover property ($fell(selection_lock_bit));
  c_bidir: cover property (in_sel[0] == ppr_pkg::PIN_C0 &&
    out_sel[16] == ppr_pkg::OUT_SEL_SYNC1_CLK);
endmodule
`default_nettype wire
